/* File: src/qp_defs.svh */
// Constants for the quad potentiometer two-wire slave port and its master
`ifndef QP_DEFS_SVH
`define QP_DEFS_SVH

// Core clock rate
`define QP_CLK_KHZ            100000
// Fastest serial clock the port accepts
`define QP_SCL_MAX_KHZ        400
// Non-volatile program cycle, longest time
`define QP_NV_PROGRAM_TIME_MS 5
// Power-up waits before the first read and the first write
`define QP_POWERUP_READ_DELAY_MS  1
`define QP_POWERUP_WRITE_DELAY_MS 1

// Derived cycle counts: a longest time rounds down, a least time rounds up
`define QP_NV_PROGRAM_CYCLES  (`QP_NV_PROGRAM_TIME_MS * `QP_CLK_KHZ)
`define QP_POWERUP_CYCLES     (`QP_POWERUP_READ_DELAY_MS * `QP_CLK_KHZ)
`define QP_SCL_QTR_CYCLES     ((`QP_CLK_KHZ + 4 * `QP_SCL_MAX_KHZ - 1) / (4 * `QP_SCL_MAX_KHZ))

// Instruction byte fields
`define QP_OPCODE_MSB   7
`define QP_OPCODE_LSB   4
`define QP_REGSEL_MSB   3
`define QP_REGSEL_LSB   2
`define QP_POTSEL_MSB   1
`define QP_POTSEL_LSB   0

// Opcodes that matter to the port
`define QP_OP_READ_WIPER  4'h9
`define QP_OP_READ_DATA   4'hB
`define QP_OP_WRITE_DATA  4'hC

// Bits in a byte, and the ack clock index
`define QP_BYTE_BITS    4'h8

// Write queue depth
`define QP_FIFO_DEPTH   32

`endif

/* File: src/qp_pkg.sv */
// Types shared by both ends of the potentiometer serial port
package qp_pkg;

  // Slave sequencer states
  typedef enum logic [2:0] {
    QP_D_IDLE  = 3'b000,
    QP_D_RX    = 3'b001,
    QP_D_ACK   = 3'b010,
    QP_D_TX    = 3'b011,
    QP_D_TXACK = 3'b100,
    QP_D_WAIT  = 3'b101
  } qp_dev_state_e;

  // Master sequencer states
  typedef enum logic [2:0] {
    QP_H_POWER = 3'b000,
    QP_H_IDLE  = 3'b001,
    QP_H_START = 3'b010,
    QP_H_BIT   = 3'b011,
    QP_H_STOP  = 3'b100
  } qp_host_state_e;

  // Complete slave state
  typedef struct packed {
    logic          scl_m;
    logic          scl_s;
    logic          scl_p;
    logic          sda_m;
    logic          sda_s;
    logic          sda_p;
    logic [3:0]    strap_m;
    logic [3:0]    strap_s;
    logic          wp_m;
    logic          wp_s;
    qp_dev_state_e st;
    logic [3:0]    cnt;
    logic [1:0]    idx;
    logic [7:0]    sh;
    logic [7:0]    instr;
    logic          drive;
    logic          mack;
    logic          push;
    logic          nv_pend;
    logic          busy;
    logic [31:0]   timer;
  } qp_dev_s;

  // Complete master state
  typedef struct packed {
    qp_host_state_e st;
    logic [31:0]    pu_cnt;
    logic [15:0]    qcnt;
    logic [1:0]     q;
    logic [3:0]     bitn;
    logic [1:0]     idx;
    logic [7:0]     sh;
    logic           scl;
    logic           sda;
    logic           sda_m;
    logic           sda_s;
    logic           rx;
    logic           poll;
    logic           ack_ok;
    logic [3:0]     addr;
    logic [7:0]     instr;
    logic [7:0]     data;
    logic           rsp_valid;
    logic [7:0]     rsp_data;
  } qp_host_s;

endpackage

/* File: src/qp_bus_if.sv */
// Two-wire bus between the master end and the potentiometer slave end
interface qp_bus_if;
  logic scl_o;
  logic scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wired-AND with pull-ups: a line is low only where someone drives it low
  assign scl = ~(~scl_oe_n & ~scl_o);
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));

  modport master (output scl_o, output scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
  modport slave  (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

/* File: src/qp_dev.sv */
// Potentiometer slave end of the two-wire port, with its write queue
//
// Behaviour
// - Detect start: data falls, clock high
// - Detect stop: data rises, clock high
// - Data change during clock high means start/stop
// - Ignore bus and drive nothing before start
// - Address byte: type nibble, then device nibble
// - Device nibble must equal four strap pins
// - Acknowledge matching address, silence on mismatch
// - Receiver holds data low on ninth clock
// - Acknowledge every byte of a write; the data byte is refused while the write queue is full or write-protect is low
// - Read: send eight bits, then sample ack
// - Master withholds ack: stop sending, await stop
// - Write is address, instruction, data, stop
// - Stop after data-register write starts programming
// - While programming, release data and answer nothing
// - Programming lasts at most five milliseconds
// - Poll: no ack while busy, ack after
// - Master waits one millisecond after power-up
// - Master starts on idle bus, drives clock
// - Write-protect low: refuse ack after data byte
// - Low instruction bits pick one wiper register

`include "qp_defs.svh"

module qp_dev
  import qp_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE         = 4'hA,                   // Arbitrary type code
  parameter int         NV_PROGRAM_CYCLES = `QP_NV_PROGRAM_CYCLES
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Two-wire bus
  qp_bus_if.slave         BUS,
  // Straps and write protect
  input  wire logic       STRAP_ADDR_BIT_0,
  input  wire logic       STRAP_ADDR_BIT_1,
  input  wire logic       STRAP_ADDR_BIT_2,
  input  wire logic       STRAP_ADDR_BIT_3,
  input  wire logic       WP_N,
  // Read data supply
  output logic [7:0]      RD_INSTR,
  input  wire logic [7:0] RD_DATA,
  // Accepted writes
  output logic            WR_VALID,
  input  wire logic       WR_READY,
  output logic [3:0]      WR_OPCODE,
  output logic [1:0]      WR_REG_SEL,
  output logic [1:0]      WR_POT_SEL,
  output logic [7:0]      WR_DATA,
  // Programming in progress
  output logic            NV_BUSY
);
  import qp_pkg::*;

  if (NV_PROGRAM_CYCLES < 1) begin : g_chk
    $error("qp_dev NV_PROGRAM_CYCLES must be at least 1");
  end

  qp_dev_s     r;
  qp_dev_s     next_r;
  logic        rise;
  logic        fall;
  logic        start_seen;
  logic        stop_seen;
  logic        fifo_ready;
  logic [15:0] fifo_out;
  logic [3:0]  opcode;

  // Edges come from the second and third stages only
  assign rise       = r.scl_s & ~r.scl_p;
  assign fall       = ~r.scl_s & r.scl_p;
  assign start_seen = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
  assign stop_seen  = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
  assign opcode     = r.instr[`QP_OPCODE_MSB:`QP_OPCODE_LSB];

  // Open drain: only ever pulls low, released otherwise
  assign BUS.s_sda_o    = 1'b0;
  assign BUS.s_sda_oe_n = ~r.drive;
  assign RD_INSTR       = r.instr;
  assign NV_BUSY        = r.busy;

  // Write queue; a full queue refuses the data byte rather than losing it
  qp_fifo #(.W(16), .DEPTH(`QP_FIFO_DEPTH)) u_fifo (
    .CORE_CLK  (CORE_CLK),
    .RST       (RST),
    .in_valid  (r.push),
    .in_ready  (fifo_ready),
    .in_data   ({r.instr, r.sh}),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (fifo_out)
  );
  assign WR_OPCODE  = fifo_out[8+`QP_OPCODE_MSB:8+`QP_OPCODE_LSB];
  assign WR_REG_SEL = fifo_out[8+`QP_REGSEL_MSB:8+`QP_REGSEL_LSB];
  assign WR_POT_SEL = fifo_out[8+`QP_POTSEL_MSB:8+`QP_POTSEL_LSB];
  assign WR_DATA    = fifo_out[7:0];

  // Sequencer
  always_comb begin
    next_r         = r;
    // Synchronisers: the first stage feeds the second and nothing else
    next_r.scl_m   = BUS.scl;
    next_r.scl_s   = r.scl_m;
    next_r.scl_p   = r.scl_s;
    next_r.sda_m   = BUS.sda;
    next_r.sda_s   = r.sda_m;
    next_r.sda_p   = r.sda_s;
    next_r.strap_m = {STRAP_ADDR_BIT_3, STRAP_ADDR_BIT_2, STRAP_ADDR_BIT_1, STRAP_ADDR_BIT_0};
    next_r.strap_s = r.strap_m;
    next_r.wp_m    = WP_N;
    next_r.wp_s    = r.wp_m;
    next_r.push    = 1'b0;

    // Programming timer runs independently of bus activity
    if (r.busy) begin
      next_r.timer = r.timer - 32'h1;
      if (r.timer == 32'h1) begin
        next_r.busy = 1'b0;
      end
    end

    if (stop_seen) begin
      next_r.st      = QP_D_IDLE;
      next_r.drive   = 1'b0;
      next_r.nv_pend = 1'b0;
      if (r.nv_pend) begin
        next_r.busy  = 1'b1;
        next_r.timer = 32'(NV_PROGRAM_CYCLES);
      end
    end else if (start_seen) begin
      // Also a repeated start from any state
      next_r.st      = QP_D_RX;
      next_r.idx     = 2'h0;
      next_r.cnt     = 4'h0;
      next_r.drive   = 1'b0;
      next_r.nv_pend = 1'b0;
    end else begin
      unique case (r.st)
        QP_D_IDLE: begin
          next_r.drive = 1'b0;
        end
        QP_D_RX: begin
          if (rise && r.cnt != `QP_BYTE_BITS) begin
            next_r.sh  = {r.sh[6:0], r.sda_s};
            next_r.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == `QP_BYTE_BITS) begin
            next_r.cnt = 4'h0;
            unique case (r.idx)
              2'h0: begin
                // Busy also withholds the address ack, which makes polling work
                next_r.drive = (r.sh[7:4] == DEV_TYPE) && (r.sh[3:0] == r.strap_s)
                               && !r.busy;
              end
              2'h1: begin
                next_r.drive = 1'b1;
                next_r.instr = r.sh;
              end
              2'h2: begin
                next_r.drive = r.wp_s && fifo_ready;
                next_r.push  = r.wp_s && fifo_ready;
                next_r.nv_pend = r.wp_s && fifo_ready && (opcode == `QP_OP_WRITE_DATA);
              end
              default: begin
                next_r.drive = 1'b0;
              end
            endcase
            next_r.st = (next_r.drive) ? QP_D_ACK : QP_D_WAIT;
          end
        end
        QP_D_ACK: begin
          // Ack held through the ninth clock, released on its falling edge
          if (fall) begin
            next_r.drive = 1'b0;
            next_r.cnt   = 4'h0;
            if (r.idx == 2'h1 && (opcode == `QP_OP_READ_WIPER || opcode == `QP_OP_READ_DATA)) begin
              next_r.sh    = RD_DATA;
              next_r.drive = ~RD_DATA[7];
              next_r.st    = QP_D_TX;
            end else if (r.idx == 2'h2) begin
              next_r.st = QP_D_WAIT;
            end else begin
              next_r.idx = r.idx + 2'h1;
              next_r.st  = QP_D_RX;
            end
          end
        end
        QP_D_TX: begin
          if (rise) begin
            next_r.cnt = r.cnt + 4'h1;
          end else if (fall) begin
            if (r.cnt == `QP_BYTE_BITS) begin
              next_r.drive = 1'b0;
              next_r.st    = QP_D_TXACK;
            end else begin
              next_r.sh    = {r.sh[6:0], 1'b0};
              next_r.drive = ~r.sh[6];
            end
          end
        end
        QP_D_TXACK: begin
          if (rise) begin
            next_r.mack = ~r.sda_s;
          end else if (fall) begin
            if (r.mack) begin
              next_r.sh    = RD_DATA;
              next_r.drive = ~RD_DATA[7];
              next_r.cnt   = 4'h0;
              next_r.st    = QP_D_TX;
            end else begin
              next_r.st = QP_D_WAIT;
            end
          end
        end
        QP_D_WAIT: begin
          next_r.drive = 1'b0;
        end
        default: begin
          next_r.st    = QP_D_IDLE;
          next_r.drive = 1'b0;
        end
      endcase
    end
  end

  // State register; lines are assumed idle high out of reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      r <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
             st: QP_D_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule

/* File: src/qp_host.sv */
// Bus master end, which issues write, read and poll transfers, and the write queue FIFO of the slave end
`include "qp_defs.svh"

module qp_host
  import qp_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE       = 4'hA,                     // Arbitrary type code
  parameter int         POWERUP_CYCLES = `QP_POWERUP_CYCLES,
  parameter int         QTR_CYCLES     = `QP_SCL_QTR_CYCLES
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Two-wire bus
  qp_bus_if.master        BUS,
  // Command
  input  wire logic       CMD_VALID,
  output logic            CMD_READY,
  input  wire logic       CMD_POLL,
  input  wire logic [3:0] CMD_ADDR,
  input  wire logic [7:0] CMD_INSTR,
  input  wire logic [7:0] CMD_DATA,
  // Response
  output logic            RSP_VALID,
  output logic            RSP_ACK,
  output logic [7:0]      RSP_DATA
);
  import qp_pkg::*;

  // Quarter must outlast the slave's synchroniser and edge latency
  if (QTR_CYCLES < 8 || QTR_CYCLES > 65535 || POWERUP_CYCLES < 1) begin : g_chk
    $error("qp_host QTR_CYCLES must be 8..65535 and POWERUP_CYCLES at least 1");
  end

  qp_host_s r;
  qp_host_s next_r;
  logic     tick;
  logic     is_read;

  assign tick      = (r.qcnt == 16'(QTR_CYCLES - 1));
  assign is_read   = (r.instr[7:4] == `QP_OP_READ_WIPER) || (r.instr[7:4] == `QP_OP_READ_DATA);
  assign CMD_READY = (r.st == QP_H_IDLE);
  // Open drain on both lines; releasing lets the pull-up make the high level
  assign BUS.scl_o      = 1'b0;
  assign BUS.scl_oe_n   = r.scl;
  assign BUS.m_sda_o    = 1'b0;
  assign BUS.m_sda_oe_n = r.sda;
  assign RSP_VALID      = r.rsp_valid;
  assign RSP_ACK        = r.ack_ok;
  assign RSP_DATA       = r.rsp_data;

  // Sequencer, paced by a quarter-bit enable
  always_comb begin
    next_r           = r;
    next_r.sda_m     = BUS.sda;
    next_r.sda_s     = r.sda_m;
    next_r.rsp_valid = 1'b0;
    next_r.qcnt      = tick ? 16'h0 : r.qcnt + 16'h1;
    unique case (r.st)
      QP_H_POWER: begin
        next_r.qcnt   = 16'h0;
        next_r.pu_cnt = r.pu_cnt + 32'h1;
        if (r.pu_cnt == 32'(POWERUP_CYCLES - 1)) begin
          next_r.st = QP_H_IDLE;
        end
      end
      QP_H_IDLE: begin
        next_r.qcnt = 16'h0;
        if (CMD_VALID) begin
          next_r.st     = QP_H_START;
          next_r.q      = 2'h0;
          next_r.poll   = CMD_POLL;
          next_r.addr   = CMD_ADDR;
          next_r.instr  = CMD_INSTR;
          next_r.data   = CMD_DATA;
          next_r.ack_ok = 1'b0;
        end
      end
      QP_H_START: begin
        if (tick) begin
          next_r.q = r.q + 2'h1;
          if (r.q == 2'h0) begin
            next_r.sda = 1'b0;
          end else if (r.q == 2'h1) begin
            next_r.scl  = 1'b0;
            next_r.st   = QP_H_BIT;
            next_r.q    = 2'h0;
            next_r.bitn = 4'h0;
            next_r.idx  = 2'h0;
            next_r.rx   = 1'b0;
            next_r.sh   = {DEV_TYPE, r.addr};
          end
        end
      end
      QP_H_BIT: begin
        if (tick) begin
          next_r.q = r.q + 2'h1;
          unique case (r.q)
            2'h0: begin
              // Data only changes while the clock is low
              if (r.bitn != `QP_BYTE_BITS) begin
                next_r.sda = r.rx | r.sh[7];
              end else begin
                next_r.sda = 1'b1;
              end
            end
            2'h1: begin
              next_r.scl = 1'b1;
            end
            2'h2: begin
              if (r.bitn != `QP_BYTE_BITS && r.rx) begin
                next_r.sh = {r.sh[6:0], r.sda_s};
              end else if (r.bitn == `QP_BYTE_BITS && !r.rx) begin
                next_r.ack_ok = ~r.sda_s;
              end
            end
            2'h3: begin
              next_r.scl = 1'b0;
              if (r.bitn != `QP_BYTE_BITS) begin
                if (!r.rx) begin
                  next_r.sh = {r.sh[6:0], 1'b0};
                end
                next_r.bitn = r.bitn + 4'h1;
              end else if ((!r.rx && !r.ack_ok) || r.poll || r.idx == 2'h2) begin
                next_r.rsp_data = r.sh;
                next_r.st       = QP_H_STOP;
              end else begin
                next_r.idx  = r.idx + 2'h1;
                next_r.bitn = 4'h0;
                next_r.rx   = (r.idx == 2'h1) && is_read;
                next_r.sh   = (r.idx == 2'h0) ? r.instr : r.data;
              end
            end
          endcase
        end
      end
      QP_H_STOP: begin
        if (tick) begin
          next_r.q = r.q + 2'h1;
          if (r.q == 2'h0) begin
            next_r.sda = 1'b0;
          end else if (r.q == 2'h1) begin
            next_r.scl = 1'b1;
          end else if (r.q == 2'h2) begin
            next_r.sda = 1'b1;
          end else begin
            next_r.rsp_valid = 1'b1;
            next_r.st        = QP_H_IDLE;
          end
        end
      end
      default: begin
        next_r.st = QP_H_IDLE;
      end
    endcase
  end

  // State register; both lines released from reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      r <= '{st: QP_H_POWER, scl: 1'b1, sda: 1'b1, sda_m: 1'b1, sda_s: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule

// Simple synchronous FIFO, all state in one struct
module qp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = `QP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         CORE_CLK,
  input  wire logic         RST,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } qp_fifo_s;

  qp_fifo_s r;
  qp_fifo_s next_r;
  logic     do_wr;
  logic     do_rd;

  // Pointer arithmetic wraps only for a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("qp_fifo DEPTH must be a power of two, at least 2");
  end

  // Honest flags from the occupancy count
  assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // Next state
  always_comb begin
    next_r = r;
    if (do_wr) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp        = r.wp + 1'b1;
    end
    if (do_rd) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.cnt = r.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  // State register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

/* File: tb/qp_port_checker.sv */
// Protocol checker on the two-wire bus between the master end and the slave end
module qp_port_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Resolved lines and data pull-down enables
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Stop must follow a refused byte within a few quarters at the bench clock rate
  localparam int STOP_MAX = 80;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       fr;
    logic [3:0] bp;
    logic [3:0] nb;
  } qp_chk_s;

  qp_chk_s r;
  qp_chk_s next_r;
  logic    start_ev;
  logic    stop_ev;
  logic    rise;

  // Line events from one cycle of history
  assign start_ev = r.scl & scl & r.sda & ~sda;
  assign stop_ev  = r.scl & scl & ~r.sda & sda;
  assign rise     = scl & ~r.scl;

  // Frame, bit and byte position; position is the count of clock rises in the byte
  always_comb begin
    next_r     = r;
    next_r.scl = scl;
    next_r.sda = sda;
    if (start_ev) begin
      next_r.fr = 1'b1;
      next_r.bp = 4'h0;
      next_r.nb = 4'h0;
    end else if (stop_ev) begin
      next_r.fr = 1'b0;
    end else if (rise && r.fr) begin
      next_r.bp = (r.bp == 4'h8) ? 4'h0 : r.bp + 4'h1;
      next_r.nb = (r.bp == 4'h8) ? r.nb + 4'h1 : r.nb;
    end
  end

  // Idle bus reads high on both lines
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      r <= {2'h3, 9'h000};
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence start_seen;
    start_ev;
  endsequence

  sequence nack_seen;
    rise && r.bp == 4'h8 && sda;
  endsequence

  a_idle_no_drive: assert property (!r.fr [*5] |-> s_sda_oe_n)
    else $error("Slave pulls data outside a frame");
  a_idle_scl_high: assert property (!r.fr |-> scl)
    else $error("Clock low outside a frame");
  a_drive_scl_low: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("Slave changed data while clock high");
  a_start_scl_hold: assert property (start_seen |-> scl [*4])
    else $error("Clock not held high after start");
  a_nack_then_stop: assert property (nack_seen |-> ##[1:STOP_MAX] stop_ev)
    else $error("No stop after a refused byte");
  a_ack_slot_only: assert property (rise && !s_sda_oe_n |-> r.bp == 4'h8 || r.nb >= 4'h2)
    else $error("Slave pulls data outside ack slot or read byte");
  a_master_released: assert property (rise && !s_sda_oe_n |-> m_sda_oe_n)
    else $error("Master drives data while slave answers");
  a_master_data_stable: assert property (rise |-> ##1 $stable(m_sda_oe_n) [*3])
    else $error("Master changed data while clock high");
  // Looks at the second clock of a byte: the clock rise of the stop would pass for a fourth byte
  a_three_bytes_max: assert property (rise && r.bp == 4'h1 |-> r.nb < 4'h3)
    else $error("More than three bytes in a frame");
endmodule

/* File: tb/quad_pot_i2c_slave_port_bench.sv */
// Bench: master end and slave end joined over the two-wire bus, with the protocol checker
module quad_pot_i2c_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Short programming cycle keeps the run brief
  localparam int NV = 2000;

  typedef struct packed {
    logic       p;
    logic [3:0] a;
    logic [7:0] i;
    logic [7:0] d;
    logic       ack;
  } qp_row_s;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cv = 1'b0;
  logic        cp = 1'b0;
  logic        wp_n = 1'b1;
  logic        wr_rdy = 1'b0;
  logic [3:0]  ca = 4'h0;
  logic [3:0]  strap = 4'h5;
  logic [7:0]  ci = 8'h00;
  logic [7:0]  cd = 8'h00;
  logic        crdy, rv, rack, wv, busy;
  logic [7:0]  rdat, rinstr, wdat;
  logic [3:0]  wop;
  logic [1:0]  wreg, wpot;
  logic [15:0] drained[$];
  int          errors = 0;
  int          num_checks = 0;
  int          n;
  int          acks;
  // Poll, address, instruction, data, expected ack
  qp_row_s     rows[6] = '{{1'b0, 4'h5, 8'hA1, 8'h2A, 1'b1}, {1'b0, 4'h6, 8'hA2, 8'h11, 1'b0},
                           {1'b0, 4'h5, 8'h93, 8'h00, 1'b1}, {1'b0, 4'h5, 8'hB6, 8'h00, 1'b1},
                           {1'b1, 4'h5, 8'h00, 8'h00, 1'b1}, {1'b1, 4'h9, 8'h00, 8'h00, 1'b0}};

  always #5 clk = ~clk;

  qp_bus_if bus ();

  qp_host #(.DEV_TYPE(4'hA), .POWERUP_CYCLES(50), .QTR_CYCLES(8)) u_qp_host (
    .CORE_CLK(clk), .RST(rst), .BUS(bus.master), .CMD_VALID(cv), .CMD_READY(crdy), .CMD_POLL(cp),
    .CMD_ADDR(ca), .CMD_INSTR(ci), .CMD_DATA(cd), .RSP_VALID(rv), .RSP_ACK(rack), .RSP_DATA(rdat));

  // Read data is the instruction scrambled, so each read has a known answer
  qp_dev #(.DEV_TYPE(4'hA), .NV_PROGRAM_CYCLES(NV)) u_qp_dev (
    .CORE_CLK(clk), .RST(rst), .BUS(bus.slave), .STRAP_ADDR_BIT_0(strap[0]), .STRAP_ADDR_BIT_1(strap[1]),
    .STRAP_ADDR_BIT_2(strap[2]), .STRAP_ADDR_BIT_3(strap[3]), .WP_N(wp_n), .RD_INSTR(rinstr),
    .RD_DATA(rinstr ^ 8'h3C), .WR_VALID(wv), .WR_READY(wr_rdy), .WR_OPCODE(wop), .WR_REG_SEL(wreg),
    .WR_POT_SEL(wpot), .WR_DATA(wdat), .NV_BUSY(busy));

  qp_port_checker u_qp_port_checker (.CORE_CLK(clk), .RST(rst), .scl(bus.scl), .sda(bus.sda),
                                     .m_sda_oe_n(bus.m_sda_oe_n), .s_sda_oe_n(bus.s_sda_oe_n));

  // Record every word taken from the write queue
  always @(posedge clk) begin
    if (wv === 1'b1 && wr_rdy === 1'b1) begin
      drained.push_back({wop, wreg, wpot, wdat});
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One command through the master end; held until taken, then bounded wait for the answer
  task automatic cmd(input logic p, input logic [3:0] a, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    cp <= p;
    ca <= a;
    ci <= i;
    cd <= d;
    cv <= 1'b1;
    #1;
    n = 0;
    while (crdy !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    cv <= 1'b0;
    #1;
    while (rv !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 5000) begin
      errors++;
      tally_and_finish();
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(16'({wv, busy, bus.sda, bus.scl}), 16'h0003);
    foreach (rows[k]) begin
      cmd(rows[k].p, rows[k].a, rows[k].i, rows[k].d);
      check(16'(rack), 16'(rows[k].ack));
      if (rows[k].i[7:4] == 4'h9 || rows[k].i[7:4] == 4'hB) begin
        check(16'(rdat), 16'(rows[k].i ^ 8'h3C));
      end
    end
    // Protected write: address and instruction taken, data refused, nothing programmed
    @(posedge clk);
    wp_n <= 1'b0;
    cmd(1'b0, 4'h5, 8'hC4, 8'h15);
    repeat (5) @(posedge clk);
    check(16'({rack, busy}), 16'h0000);
    wp_n <= 1'b1;
    cmd(1'b0, 4'h5, 8'hC7, 8'h3F);
    repeat (5) @(posedge clk);
    check(16'({rack, busy}), 16'h0003);
    cmd(1'b1, 4'h5, 8'h00, 8'h00);
    check(16'({rack, busy}), 16'h0001);
    n = 0;
    while (busy !== 1'b0 && n < NV) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(busy), 16'h0000);
    cmd(1'b1, 4'h5, 8'h00, 8'h00);
    check(16'(rack), 16'h0001);
    // Two words already queued; fill with the drain stalled until the queue refuses
    acks = 0;
    for (int k = 0; k < 31; k++) begin
      cmd(1'b0, 4'h5, {6'h28, k[1:0]}, k[7:0]);
      if (rack === 1'b1) begin
        acks++;
      end
    end
    check(16'(acks), 16'h001E);
    check(16'(rack), 16'h0000);
    @(posedge clk);
    wr_rdy <= 1'b1;
    repeat (40) @(posedge clk);
    check(16'(drained.size()), 16'h0020);
    check(drained[0], 16'hA12A);
    check(drained[1], 16'hC73F);
    check(drained[31], 16'hA11D);
    check(16'(wv), 16'h0000);
    tally_and_finish();
  end
endmodule
